// ### hdl/mmc_ctrl.sv
/*
 * mmc_ctrl: translation registers, fetch strobe mode, internal I/O decode
 * and relocation, I/O halt mode.
 * Assumes the core gives 16-bit I/O addresses with read/write strobes,
 * one-cycle cycle markers for fetch kinds, and samples read data
 * in the cycle after the strobe.
 */
// What this block does
// - bank base, in 4-KB units, forms the 20-bit bank-area physical address.
// - reset clears the bank base register.
// - upper common base serves common area 1; reset clears it.
// - area bounds split 64-KB space into up to three regions.
// - bits 7-4 give common area 1 start page; reset all ones.
// - bits 3-0 give bank area start page; reset all ones.
// - reset sets the fetch strobe enable bit.
// - with enable, strobe low on fetch, level-0 ack, first NMI ack cycle.
// - with enable, return-from-interrupt fetched only once.
// - without enable, strobe stays high on instruction fetch.
// - without enable, return-from-interrupt refetched with strobe asserted.
// - I/O control bits 7,6 relocate internal I/O; reset clears them.
// - internal I/O decoded only when upper eight address bits are zero.
// - bit 5 enters I/O halt; cleared by software or reset.
`timescale 1ns/1ps
module mmc_ctrl
  import mmc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  input  wire logic [15:0] i_logical_addr,
  input  wire logic        i_opcode_fetch,
  input  wire logic        i_level0_ack,
  input  wire logic        i_nmi_ack_first,
  input  wire logic        i_return_from_interrupt_fetched,
  output logic      [19:0] o_physical_addr,
  output mmc_region_t      o_region,
  output logic             o_internal_io_sel,
  output logic      [5:0]  o_internal_io_offset,
  output logic      [7:0]  o_io_rdata,
  output logic             o_io_rvalid,
  output logic             o_fetch_cycle_strobe_n,
  output logic             o_return_from_interrupt_refetch,
  output logic             o_io_halt_mode
);
  logic [7:0] upper_common_base_ff;
  logic [7:0] bank_area_base_ff;
  logic [7:0] area_boundaries_ff;
  logic       fetch_strobe_enable_ff;
  logic [1:0] io_relocate_ff;
  logic       io_halt_enable_ff;
  logic       fetch_strobe_n_ff;
  logic       nxt_fetch_strobe_n;
  logic       return_from_interrupt_refetch_ff;
  logic [7:0] io_rdata_ff;
  logic       io_rvalid_ff;
  logic [7:0] int_addr;
  logic       int_hit;
  logic       wr_hit;

  // internal block sits on a 64-byte boundary of the low page
  always_comb begin
    int_hit  = (i_io_addr[15:8] == IO_PAGE_HIGH)
            && (i_io_addr[7:IO_BLOCK_SHIFT] == io_relocate_ff);
    int_addr = {2'h0, i_io_addr[IO_BLOCK_SHIFT-1:0]};
    wr_hit   = int_hit && i_io_wr;
  end

  assign o_internal_io_sel    = int_hit && (i_io_wr || i_io_rd);
  assign o_internal_io_offset = i_io_addr[IO_BLOCK_SHIFT-1:0];

  // translation registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      upper_common_base_ff <= RST_BASE;
      bank_area_base_ff    <= RST_BASE;
      area_boundaries_ff   <= RST_AREA_BOUNDARIES;
    end else if (wr_hit) begin
      if (int_addr == OFS_UPPER_COMMON_BASE) begin
        upper_common_base_ff <= i_io_wdata;
      end
      if (int_addr == OFS_BANK_AREA_BASE) begin
        bank_area_base_ff <= i_io_wdata;
      end
      if (int_addr == OFS_AREA_BOUNDARIES) begin
        area_boundaries_ff <= i_io_wdata;
      end
    end
  end

  // mode and I/O control registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fetch_strobe_enable_ff <= RST_FETCH_STROBE_EN;
      io_relocate_ff         <= RST_IO_RELOCATE;
      io_halt_enable_ff      <= RST_IO_HALT;
    end else if (wr_hit) begin
      if (int_addr == OFS_OPERATION_MODE) begin
        fetch_strobe_enable_ff <= i_io_wdata[BIT_FETCH_STROBE_EN];
      end
      if (int_addr == OFS_IO_SPACE_CONTROL) begin
        io_relocate_ff    <= {i_io_wdata[BIT_IO_RELOCATE_HI],
                              i_io_wdata[BIT_IO_RELOCATE_LO]};
        io_halt_enable_ff <= i_io_wdata[BIT_IO_HALT_ENABLE];
      end
    end
  end

  assign o_io_halt_mode = io_halt_enable_ff;

  // fetch strobe and return-from-interrupt refetch
  always_comb begin
    if (fetch_strobe_enable_ff) begin
      nxt_fetch_strobe_n = !(i_opcode_fetch || i_level0_ack
                             || i_nmi_ack_first);
    end else begin
      nxt_fetch_strobe_n = !return_from_interrupt_refetch_ff;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fetch_strobe_n_ff <= 1'b1;
      return_from_interrupt_refetch_ff   <= 1'b0;
    end else begin
      fetch_strobe_n_ff <= nxt_fetch_strobe_n;
      return_from_interrupt_refetch_ff   <= i_return_from_interrupt_fetched && !fetch_strobe_enable_ff
                           && !return_from_interrupt_refetch_ff;
    end
  end

  assign o_fetch_cycle_strobe_n = fetch_strobe_n_ff;
  assign o_return_from_interrupt_refetch         = return_from_interrupt_refetch_ff;

  // register read port, one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      io_rdata_ff  <= RD_PAD;
      io_rvalid_ff <= 1'b0;
    end else begin
      io_rvalid_ff <= int_hit && i_io_rd;
      if (int_hit && i_io_rd) begin
        unique case (int_addr)
          OFS_UPPER_COMMON_BASE: io_rdata_ff <= upper_common_base_ff;
          OFS_BANK_AREA_BASE:    io_rdata_ff <= bank_area_base_ff;
          OFS_AREA_BOUNDARIES:   io_rdata_ff <= area_boundaries_ff;
          OFS_OPERATION_MODE:    io_rdata_ff <= {fetch_strobe_enable_ff,
                                                 OMC_UNUSED_RD};
          OFS_IO_SPACE_CONTROL:  io_rdata_ff <= {io_relocate_ff,
                                                 io_halt_enable_ff,
                                                 ICR_UNUSED_RD};
          default:               io_rdata_ff <= RD_PAD;
        endcase
      end
    end
  end

  assign o_io_rdata  = io_rdata_ff;
  assign o_io_rvalid = io_rvalid_ff;

  mmc_translate u_translate (
    .i_logical_addr            (i_logical_addr),
    .i_bank_start_page         (area_boundaries_ff[3:0]),
    .i_upper_common_start_page (area_boundaries_ff[7:4]),
    .i_bank_area_base          (bank_area_base_ff),
    .i_upper_common_base       (upper_common_base_ff),
    .o_physical_addr           (o_physical_addr),
    .o_region                  (o_region)
  );

  property p_reset_values;
    @(posedge i_core_clk)
    i_rst |=> bank_area_base_ff == RST_BASE
      && area_boundaries_ff == RST_AREA_BOUNDARIES && fetch_strobe_enable_ff;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values wrong");

  property p_upper_base_reset;
    @(posedge i_core_clk) i_rst |=> upper_common_base_ff == RST_BASE;
  endproperty
  a_upper_base_reset: assert property (p_upper_base_reset)
    else $error("upper common base not cleared");

  property p_bank_translate;
    @(posedge i_core_clk) disable iff (i_rst)
    o_region == MMC_REGION_BANK |->
      o_physical_addr == {4'h0, i_logical_addr}
                       + {bank_area_base_ff, 12'h000};
  endproperty
  a_bank_translate: assert property (p_bank_translate)
    else $error("bank address wrong");

  property p_region_pick;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_logical_addr[15:12] < area_boundaries_ff[3:0])
      |-> o_region == MMC_REGION_COMMON0;
  endproperty
  a_region_pick: assert property (p_region_pick)
    else $error("region pick wrong");

  property p_strobe_on;
    @(posedge i_core_clk) disable iff (i_rst)
    fetch_strobe_enable_ff && i_opcode_fetch |=> !o_fetch_cycle_strobe_n;
  endproperty
  a_strobe_on: assert property (p_strobe_on)
    else $error("fetch strobe missing");

  property p_strobe_off;
    @(posedge i_core_clk) disable iff (i_rst)
    !fetch_strobe_enable_ff && !return_from_interrupt_refetch_ff
      |=> o_fetch_cycle_strobe_n;
  endproperty
  a_strobe_off: assert property (p_strobe_off)
    else $error("fetch strobe driven while disabled");

  property p_refetch;
    @(posedge i_core_clk) disable iff (i_rst)
    i_return_from_interrupt_fetched && !fetch_strobe_enable_ff && !return_from_interrupt_refetch_ff
      |=> return_from_interrupt_refetch_ff ##1 !o_fetch_cycle_strobe_n;
  endproperty
  a_refetch: assert property (p_refetch)
    else $error("refetch not issued");

  property p_no_refetch;
    @(posedge i_core_clk) disable iff (i_rst)
    fetch_strobe_enable_ff |=> !return_from_interrupt_refetch_ff;
  endproperty
  a_no_refetch: assert property (p_no_refetch)
    else $error("refetch while strobe enabled");

  property p_decode_high;
    @(posedge i_core_clk) disable iff (i_rst)
    i_io_addr[15:8] != IO_PAGE_HIGH |-> !o_internal_io_sel;
  endproperty
  a_decode_high: assert property (p_decode_high)
    else $error("decode with upper bits set");

  property p_halt_write;
    @(posedge i_core_clk) disable iff (i_rst)
    wr_hit && int_addr == OFS_IO_SPACE_CONTROL
      |=> o_io_halt_mode == $past(i_io_wdata[BIT_IO_HALT_ENABLE]);
  endproperty
  a_halt_write: assert property (p_halt_write)
    else $error("halt bit not stored");

  property p_common1_translate;
    @(posedge i_core_clk) disable iff (i_rst)
    o_region == MMC_REGION_COMMON1 |->
      o_physical_addr == {4'h0, i_logical_addr}
                       + {upper_common_base_ff, 12'h000};
  endproperty
  a_common1_translate: assert property (p_common1_translate)
    else $error("common area 1 address wrong");

  property p_common0_translate;
    @(posedge i_core_clk) disable iff (i_rst)
    o_region == MMC_REGION_COMMON0 |->
      o_physical_addr == {4'h0, i_logical_addr};
  endproperty
  a_common0_translate: assert property (p_common0_translate)
    else $error("common area 0 address wrong");

  property p_upper_region;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_logical_addr[15:12] >= area_boundaries_ff[7:4])
      |-> o_region == MMC_REGION_COMMON1;
  endproperty
  a_upper_region: assert property (p_upper_region)
    else $error("common area 1 not selected");

  property p_bank_region;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_logical_addr[15:12] >= area_boundaries_ff[3:0])
      && (i_logical_addr[15:12] < area_boundaries_ff[7:4])
      |-> o_region == MMC_REGION_BANK;
  endproperty
  a_bank_region: assert property (p_bank_region)
    else $error("bank area not selected");

  property p_ack_strobe;
    @(posedge i_core_clk) disable iff (i_rst)
    fetch_strobe_enable_ff && (i_level0_ack || i_nmi_ack_first)
      |=> !o_fetch_cycle_strobe_n;
  endproperty
  a_ack_strobe: assert property (p_ack_strobe)
    else $error("acknowledge strobe missing");

  property p_io_ctrl_reset;
    @(posedge i_core_clk)
    i_rst |=> io_relocate_ff == RST_IO_RELOCATE && !o_io_halt_mode;
  endproperty
  a_io_ctrl_reset: assert property (p_io_ctrl_reset)
    else $error("I/O control not cleared");

  property p_block_miss;
    @(posedge i_core_clk) disable iff (i_rst)
    i_io_addr[7:IO_BLOCK_SHIFT] != io_relocate_ff |-> !o_internal_io_sel;
  endproperty
  a_block_miss: assert property (p_block_miss)
    else $error("decode outside relocated block");

  c_bank_access: cover property (@(posedge i_core_clk)
    o_region == MMC_REGION_BANK);
  c_refetch: cover property (@(posedge i_core_clk) return_from_interrupt_refetch_ff);
  c_relocated: cover property (@(posedge i_core_clk)
    o_internal_io_sel && io_relocate_ff != RST_IO_RELOCATE);
  c_halt_mode: cover property (@(posedge i_core_clk)
    o_io_halt_mode && !i_rst);
  c_ack_strobe: cover property (@(posedge i_core_clk)
    fetch_strobe_enable_ff && i_nmi_ack_first);
endmodule

// ### hdl/mmc_pkg.sv
/*
 * mmc_pkg: register offsets, field positions, reset values and bounds for
 * the address translation, fetch strobe mode and internal I/O control block.
 * Assumes one core clock; the core presents internal I/O accesses
 * as 16-bit addresses with strobes.
 */
package mmc_pkg;
  localparam logic [7:0]  OFS_UPPER_COMMON_BASE = 8'h38;
  localparam logic [7:0]  OFS_BANK_AREA_BASE    = 8'h39;
  localparam logic [7:0]  OFS_AREA_BOUNDARIES   = 8'h3a;
  localparam logic [7:0]  OFS_OPERATION_MODE    = 8'h3e;
  localparam logic [7:0]  OFS_IO_SPACE_CONTROL  = 8'h3f;

  localparam logic [7:0]  RST_BASE              = 8'h00;
  localparam logic [7:0]  RST_AREA_BOUNDARIES   = 8'hff;
  localparam logic        RST_FETCH_STROBE_EN   = 1'b1;
  localparam logic [1:0]  RST_IO_RELOCATE       = 2'h0;
  localparam logic        RST_IO_HALT           = 1'b0;

  localparam int          BIT_FETCH_STROBE_EN   = 7;
  localparam int          BIT_IO_RELOCATE_HI    = 7;
  localparam int          BIT_IO_RELOCATE_LO    = 6;
  localparam int          BIT_IO_HALT_ENABLE    = 5;

  localparam int          PAGE_SHIFT            = 12;
  localparam int          IO_BLOCK_SHIFT        = 6;
  localparam logic [7:0]  IO_PAGE_HIGH          = 8'h00;
  localparam logic [7:0]  RD_PAD                = 8'h00;
  localparam logic [6:0]  OMC_UNUSED_RD         = 7'h7f;
  localparam logic [4:0]  ICR_UNUSED_RD         = 5'h1f;

  typedef enum logic [1:0] {
    MMC_REGION_COMMON0,
    MMC_REGION_BANK,
    MMC_REGION_COMMON1
  } mmc_region_t;
endpackage

// ### hdl/mmc_translate.sv
/*
 * mmc_translate: maps a 16-bit logical address to a 20-bit physical one.
 * Assumes the bounds and bases come straight from the register file.
 */
`timescale 1ns/1ps
module mmc_translate
  import mmc_pkg::*;
(
  input  wire logic [15:0] i_logical_addr,
  input  wire logic [3:0]  i_bank_start_page,
  input  wire logic [3:0]  i_upper_common_start_page,
  input  wire logic [7:0]  i_bank_area_base,
  input  wire logic [7:0]  i_upper_common_base,
  output logic      [19:0] o_physical_addr,
  output mmc_region_t      o_region
);
  logic [7:0] base;

  always_comb begin
    if (i_logical_addr[15:12] >= i_upper_common_start_page) begin
      o_region = MMC_REGION_COMMON1;
      base     = i_upper_common_base;
    end else if (i_logical_addr[15:12] >= i_bank_start_page) begin
      o_region = MMC_REGION_BANK;
      base     = i_bank_area_base;
    end else begin
      o_region = MMC_REGION_COMMON0;
      base     = RST_BASE;
    end
    o_physical_addr = {4'h0, i_logical_addr}
                    + {base, {PAGE_SHIFT{1'b0}}};
  end
endmodule

// ### sim/mmc_ctrl_test.sv
/*
 * mmc_ctrl_test: self-checking bench for mmc_ctrl.
 * Assumes a 100 MHz core clock; inputs change on the falling edge.
 */
`timescale 1ns/1ps
module mmc_ctrl_test;
  import mmc_pkg::*;
  typedef struct packed {
    logic [15:0] la;
    logic [19:0] pa;
    logic [1:0]  rg;
  } mmc_row_t;
  localparam mmc_row_t ROWS [6] = '{
    '{16'h0123, 20'h00123, 2'h0}, '{16'h3fff, 20'h03fff, 2'h0},
    '{16'h4000, 20'h16000, 2'h1}, '{16'hbfff, 20'h1dfff, 2'h1},
    '{16'hc000, 20'h40000, 2'h2}, '{16'hffff, 20'h43fff, 2'h2}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  mk = 4'h0;
  logic [15:0] ioa = 16'h0000;
  logic [15:0] la = 16'h0000;
  logic [7:0]  wd = 8'h00;
  logic [19:0] pa;
  mmc_region_t rg;
  logic        sel;
  logic [5:0]  ofs;
  logic [7:0]  rdat;
  logic        rvld;
  logic        stb_n;
  logic        refetch;
  logic        halt;
  logic [7:0]  cnt;
  int          error_cnt = 0;
  int          cmp_count = 0;
  always #5 clk = ~clk;
  mmc_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_io_addr(ioa),
    .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wd), .i_logical_addr(la),
    .i_opcode_fetch(mk[0]), .i_level0_ack(mk[1]), .i_nmi_ack_first(mk[2]),
    .i_return_from_interrupt_fetched(mk[3]), .o_physical_addr(pa), .o_region(rg),
    .o_internal_io_sel(sel), .o_internal_io_offset(ofs),
    .o_io_rdata(rdat), .o_io_rvalid(rvld), .o_fetch_cycle_strobe_n(stb_n),
    .o_return_from_interrupt_refetch(refetch), .o_io_halt_mode(halt));
  mmc_legacy_periph far_u (.i_core_clk(clk), .i_rst(rst),
    .i_fetch_cycle_strobe_n(stb_n), .o_strobe_cnt(cnt));
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    ioa = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e,
                        input logic h);
    @(negedge clk);
    ioa = a;
    rd = 1'b1;
    #1;
    chk(sel, h);
    if (h) chk(ofs, a[5:0]);
    @(negedge clk);
    rd = 1'b0;
    chk(rvld, h);
    if (h) chk(rdat, e);
  endtask
  task automatic xl(input mmc_row_t r);
    @(negedge clk);
    la = r.la;
    #1;
    chk(pa, r.pa);
    chk(rg, r.rg);
  endtask
  task automatic mark(input int k, input logic ref_e, input logic lo);
    logic [7:0] c0;
    c0 = cnt;
    @(negedge clk);
    mk = 4'h1 << k;
    @(negedge clk);
    mk = 4'h0;
    chk(refetch, ref_e);
    if (!ref_e) chk(stb_n, !lo);
    @(negedge clk);
    if (ref_e) chk(stb_n, !lo);
    @(negedge clk);
    chk(cnt - c0, lo);
  endtask
  task automatic reset_chk();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(stb_n, 1'b1);
    chk(halt, 1'b0);
    rd_reg(16'h0038, 8'h00, 1'b1);
    rd_reg(16'h0039, 8'h00, 1'b1);
    rd_reg(16'h003a, 8'hff, 1'b1);
    rd_reg(16'h003e, 8'hff, 1'b1);
    rd_reg(16'h003f, 8'h1f, 1'b1);
    xl('{16'hf000, 20'h0f000, 2'h2});
    xl('{16'h8000, 20'h08000, 2'h0});
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    reset_chk();
    wr_reg(16'h0038, 8'h34);
    wr_reg(16'h0039, 8'h12);
    wr_reg(16'h003a, 8'hc4);
    foreach (ROWS[i]) xl(ROWS[i]);
    for (int k = 0; k < 3; k++) mark(k, 1'b0, 1'b1);
    mark(3, 1'b0, 1'b0);
    wr_reg(16'h003e, 8'h00);
    rd_reg(16'h003e, 8'h7f, 1'b1);
    mark(0, 1'b0, 1'b0);
    mark(3, 1'b1, 1'b1);
    for (int k = 1; k < 4; k++) begin
      wr_reg({8'h00, 2'(k - 1), 6'h3f}, {2'(k), 6'h00});
      rd_reg({8'h00, 2'(k), 6'h39}, 8'h12, 1'b1);
      rd_reg(16'h0039, 8'h00, 1'b0);
    end
    rd_reg(16'h01f9, 8'h00, 1'b0);
    wr_reg(16'h00ff, 8'he0);
    chk(halt, 1'b1);
    rd_reg(16'h00ff, 8'hff, 1'b1);
    wr_reg(16'h00ff, 8'hc0);
    chk(halt, 1'b0);
    wr_reg(16'h00ff, 8'he0);
    reset_chk();
    conclude();
  end
endmodule

// ### sim/mmc_legacy_periph.sv
/*
 * mmc_legacy_periph: legacy peripheral model that counts fetch strobe
 * cycles as a bus-watching decoder would.
 * Assumes the strobe is sampled on the core clock, active low.
 */
`timescale 1ns/1ps
module mmc_legacy_periph (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_fetch_cycle_strobe_n,
  output logic      [7:0] o_strobe_cnt
);
  // decode one opcode per low strobe cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_strobe_cnt <= 8'h00;
    end else if (!i_fetch_cycle_strobe_n) begin
      o_strobe_cnt <= o_strobe_cnt + 8'h01;
    end
  end
endmodule
